// file: shared/cmx_defs.vh
// Constants for the record-side converter clocking and output mixing block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef CMX_DEFS_VH
`define CMX_DEFS_VH

// Register indexes; the byte address is four times the index
`define CMX_IDX_POWER 12'h004
`define CMX_IDX_CLOCKING 12'h208
`define CMX_IDX_IF1_RATE 12'h210
`define CMX_IDX_IF2_RATE 12'h211
`define CMX_IDX_SIDETONE 12'h600
`define CMX_IDX_LEFT_ROUTE 12'h606
`define CMX_IDX_RIGHT_ROUTE 12'h607
`define CMX_IDX_STATUS 12'h6FF
`define CMX_ADDR_W 14

// Power register fields
`define CMX_BIT_PDM_LEFT 3
`define CMX_BIT_PDM_RIGHT 2
`define CMX_BIT_LEFT_CONV 1
`define CMX_BIT_RIGHT_CONV 0
`define CMX_POWER_RESET 16'h0000

// Clocking register fields
`define CMX_BIT_CORE_SRC 3
`define CMX_BIT_DSP_CLK_EN 1
`define CMX_BIT_HIGH_OSR 0
`define CMX_CLOCKING_RESET 16'h0001

// Interface rate register fields: sample rate [7:4], clock ratio [3:0]
`define CMX_RATE_RESET 16'h0083

// Sidetone register fields
`define CMX_BIT_ST_TO_IF2 1
`define CMX_BIT_ST_TO_DAC 0
`define CMX_SIDETONE_RESET 16'h0000

// Routing register fields
`define CMX_BIT_CONV_ROUTE 1
`define CMX_BIT_IF2_ROUTE 0
`define CMX_ROUTE_RESET 16'h0000

// Sample rate codes
`define CMX_SR_8K 4'h0
`define CMX_SR_11K 4'h1
`define CMX_SR_12K 4'h2
`define CMX_SR_16K 4'h3
`define CMX_SR_22K 4'h4
`define CMX_SR_24K 4'h5
`define CMX_SR_32K 4'h6
`define CMX_SR_44K 4'h7
`define CMX_SR_48K 4'h8

// Clock ratio codes 128,192,256,384,512,768,1024,1536
`define CMX_CR_128 4'h0
`define CMX_CR_192 4'h1
`define CMX_CR_256 4'h2
`define CMX_CR_384 4'h3
`define CMX_CR_512 4'h4
`define CMX_CR_768 4'h5
`define CMX_CR_1024 4'h6
`define CMX_CR_1536 4'h7

// AXI responses
`define CMX_RESP_OKAY 2'h0
`define CMX_RESP_SLVERR 2'h2

`endif

// file: core/cmx_clk_gen.v
// Converter clock generator: one-cycle enable pulses from the core clock.
// Assumes the caller supplies a validated divider and a gating enable.
`timescale 1ns/1ns
`default_nettype none

module cmx_clk_gen #(
	parameter DIV_W = 8
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Control
	input wire run,
	input wire [DIV_W-1:0] div,
	// Enable pulse
	output reg tick
);

reg [DIV_W-1:0] cnt_q;

// Counter reloads on every pulse; held at zero while gated off
always @(posedge aclk) begin
	if (!aresetn || !run) begin
		cnt_q <= {DIV_W{1'b0}};
		tick <= 1'b0;
	end else if (cnt_q >= div) begin
		cnt_q <= {DIV_W{1'b0}};
		tick <= 1'b1;
	end else begin
		cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
		tick <= 1'b0;
	end
end

endmodule // cmx_clk_gen

`default_nettype wire

// file: core/cmx_mixer.v
// Two-input saturating mixer for one output channel.
// Assumes signed two's-complement samples on the same sample strobe.
`timescale 1ns/1ns
`default_nettype none

module cmx_mixer #(
	parameter W = 24
) (
	// Inputs and gates
	input wire [W-1:0] a,
	input wire a_en,
	input wire [W-1:0] b,
	input wire b_en,
	// Mixed result
	output reg [W-1:0] y
);

reg [W:0] sum;

// Gated operands are added one bit wider, then clamped to full scale
always @* begin
	sum = (a_en ? {a[W-1], a} : {(W+1){1'b0}}) +
		(b_en ? {b[W-1], b} : {(W+1){1'b0}});
	if (sum[W] != sum[W-1])
		y = sum[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
	else
		y = sum[W-1:0];
end

endmodule // cmx_mixer

`default_nettype wire

// file: core/cmx_core.v
// Record-side converter clocking and interface-one output mixing.
// Assumes an AXI4-Lite master on aclk and sample inputs on the same clock
// (each valid is a one-cycle strobe); the microphone data pin is synchronised here.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cmx_defs.vh"

module cmx_core #(
	parameter W = 24,
	parameter DIV_W = 8
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address and data
	input wire [`CMX_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [`CMX_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Converter and microphone samples
	input wire [W-1:0] left_conv_data,
	input wire [W-1:0] right_conv_data,
	input wire conv_valid,
	input wire pdm_microphone_data,
	// Interface two input stream
	input wire [W-1:0] iface_two_left,
	input wire [W-1:0] iface_two_right,
	input wire iface_two_valid,
	// Converter control
	output reg left_conv_enable,
	output reg right_conv_enable,
	output wire conv_clk_en,
	output wire pdm_microphone_clk,
	output reg clock_config_valid,
	// Interface one output stream
	output reg [W-1:0] iface_one_left,
	output reg [W-1:0] iface_one_right,
	output reg iface_one_valid,
	// Sidetone stream
	output reg [W-1:0] sidetone_left,
	output reg [W-1:0] sidetone_right,
	output reg sidetone_to_dac,
	output reg sidetone_to_iface_two,
	output reg sidetone_valid
);

// Register state
reg [15:0] power_q;
reg [15:0] clocking_q;
reg [15:0] if1_rate_q;
reg [15:0] if2_rate_q;
reg [15:0] sidetone_q;
reg [15:0] left_route_q;
reg [15:0] right_route_q;

// Write channel holding registers
reg aw_held_q;
reg [`CMX_ADDR_W-1:0] aw_addr_q;
reg w_held_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;

// Pin synchroniser for the microphone data line
reg pdm_meta_q;
reg pdm_sync_q;
reg pdm_left_q;
reg pdm_right_q;
reg [W-1:0] pdm_left_word_q;
reg [W-1:0] pdm_right_word_q;
reg pdm_phase_q;

// Clocking selection
wire [3:0] sel_rate;
wire [3:0] sel_ratio;
wire high_osr;
wire dsp_clk_en;
wire cfg_ok;
wire any_path_on;
wire [DIV_W-1:0] div_sel;
wire tick;

// Mixer inputs and results
wire [W-1:0] left_src;
wire [W-1:0] right_src;
wire [W-1:0] mix_left;
wire [W-1:0] mix_right;

// Last interface-two pair, held between its strobes
reg [W-1:0] if2_left_hold_q;
reg [W-1:0] if2_right_hold_q;
wire [W-1:0] if2_left_now;
wire [W-1:0] if2_right_now;

// Byte-enable merge of a 16-bit register
function [15:0] merge16;
	input [15:0] old;
	input [31:0] data;
	input [3:0] strb;
	begin
		merge16 = old;
		if (strb[0])
			merge16[7:0] = data[7:0];
		if (strb[1])
			merge16[15:8] = data[15:8];
	end
endfunction

// Register index from an aligned byte address
function [11:0] reg_index;
	input [`CMX_ADDR_W-1:0] addr;
	begin
		reg_index = addr[`CMX_ADDR_W-1:2];
	end
endfunction

// Supported combination lookup; unlisted combinations are rejected
function combo_ok;
	input [3:0] sr;
	input [3:0] cr;
	input osr;
	begin
		case (sr)
		`CMX_SR_8K:
			combo_ok = osr ? (cr == `CMX_CR_512 || cr == `CMX_CR_1024 ||
				cr == `CMX_CR_1536) :
				(cr >= `CMX_CR_256 && cr <= `CMX_CR_1536);
		`CMX_SR_11K, `CMX_SR_12K:
			combo_ok = osr ? (cr == `CMX_CR_512 || cr == `CMX_CR_1024) :
				(cr >= `CMX_CR_256 && cr <= `CMX_CR_1024);
		`CMX_SR_16K:
			combo_ok = (cr >= `CMX_CR_256 && cr <= `CMX_CR_768);
		`CMX_SR_22K, `CMX_SR_24K:
			combo_ok = (cr >= `CMX_CR_256 && cr <= `CMX_CR_512);
		`CMX_SR_32K:
			combo_ok = (cr == `CMX_CR_256 || cr == `CMX_CR_384);
		`CMX_SR_44K, `CMX_SR_48K:
			combo_ok = (cr == `CMX_CR_256);
		default:
			combo_ok = 1'b0;
		endcase
	end
endfunction

// Divider from ratio: higher ratio means a larger divider, so slower enable pulses
function [DIV_W-1:0] ratio_div;
	input [3:0] cr;
	input osr;
	reg [DIV_W-1:0] base;
	begin
		case (cr)
		`CMX_CR_256: base = 8'h01;
		`CMX_CR_384: base = 8'h02;
		`CMX_CR_512: base = 8'h03;
		`CMX_CR_768: base = 8'h05;
		`CMX_CR_1024: base = 8'h07;
		`CMX_CR_1536: base = 8'h0B;
		default: base = 8'h01;
		endcase
		ratio_div = osr ? base : ((base << 1) | 8'h01);
	end
endfunction

// Source select steers which interface fields set the clocking
assign sel_rate = clocking_q[`CMX_BIT_CORE_SRC] ? if2_rate_q[7:4] :
	if1_rate_q[7:4];
assign sel_ratio = clocking_q[`CMX_BIT_CORE_SRC] ? if2_rate_q[3:0] :
	if1_rate_q[3:0];
assign high_osr = clocking_q[`CMX_BIT_HIGH_OSR];
assign dsp_clk_en = clocking_q[`CMX_BIT_DSP_CLK_EN];
assign cfg_ok = combo_ok(sel_rate, sel_ratio, high_osr);
assign div_sel = ratio_div(sel_ratio, high_osr);
assign any_path_on = power_q[`CMX_BIT_LEFT_CONV] |
	power_q[`CMX_BIT_RIGHT_CONV] | power_q[`CMX_BIT_PDM_LEFT] |
	power_q[`CMX_BIT_PDM_RIGHT];

// Converter clock only runs with the DSP clock on and a listed setting
cmx_clk_gen #(
	.DIV_W(DIV_W)
) u_clk (
	.aclk(aclk),
	.aresetn(aresetn),
	.run(dsp_clk_en & cfg_ok & any_path_on),
	.div(div_sel),
	.tick(tick)
);

assign conv_clk_en = tick;
assign pdm_microphone_clk = pdm_phase_q;

// Bus handshakes: each write channel is held until both have arrived
assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
assign s_axi_wready = !w_held_q && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

// Write path and register file
always @(posedge aclk) begin
	if (!aresetn) begin
		aw_held_q <= 1'b0;
		w_held_q <= 1'b0;
		aw_addr_q <= {`CMX_ADDR_W{1'b0}};
		w_data_q <= 32'h00000000;
		w_strb_q <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `CMX_RESP_OKAY;
		power_q <= `CMX_POWER_RESET;
		clocking_q <= `CMX_CLOCKING_RESET;
		if1_rate_q <= `CMX_RATE_RESET;
		if2_rate_q <= `CMX_RATE_RESET;
		sidetone_q <= `CMX_SIDETONE_RESET;
		left_route_q <= `CMX_ROUTE_RESET;
		right_route_q <= `CMX_ROUTE_RESET;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
		if (aw_held_q && w_held_q) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `CMX_RESP_OKAY;
			case (reg_index(aw_addr_q))
			`CMX_IDX_POWER:
				power_q <= merge16(power_q, w_data_q, w_strb_q) & 16'h000F;
			`CMX_IDX_CLOCKING:
				clocking_q <= merge16(clocking_q, w_data_q, w_strb_q) &
					16'h000B;
			`CMX_IDX_IF1_RATE:
				if1_rate_q <= merge16(if1_rate_q, w_data_q, w_strb_q) &
					16'h00FF;
			`CMX_IDX_IF2_RATE:
				if2_rate_q <= merge16(if2_rate_q, w_data_q, w_strb_q) &
					16'h00FF;
			`CMX_IDX_SIDETONE:
				sidetone_q <= merge16(sidetone_q, w_data_q, w_strb_q) &
					16'h0003;
			`CMX_IDX_LEFT_ROUTE:
				left_route_q <= merge16(left_route_q, w_data_q, w_strb_q) &
					16'h0003;
			`CMX_IDX_RIGHT_ROUTE:
				right_route_q <= merge16(right_route_q, w_data_q,
					w_strb_q) & 16'h0003;
			`CMX_IDX_STATUS: ;
			default:
				s_axi_bresp <= `CMX_RESP_SLVERR;
			endcase
		end
		if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end
end

// Read path: one cycle from address to data
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `CMX_RESP_OKAY;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= `CMX_RESP_OKAY;
		case (reg_index(s_axi_araddr))
		`CMX_IDX_POWER: s_axi_rdata <= {16'h0000, power_q};
		`CMX_IDX_CLOCKING: s_axi_rdata <= {16'h0000, clocking_q};
		`CMX_IDX_IF1_RATE: s_axi_rdata <= {16'h0000, if1_rate_q};
		`CMX_IDX_IF2_RATE: s_axi_rdata <= {16'h0000, if2_rate_q};
		`CMX_IDX_SIDETONE: s_axi_rdata <= {16'h0000, sidetone_q};
		`CMX_IDX_LEFT_ROUTE: s_axi_rdata <= {16'h0000, left_route_q};
		`CMX_IDX_RIGHT_ROUTE: s_axi_rdata <= {16'h0000, right_route_q};
		`CMX_IDX_STATUS:
			s_axi_rdata <= {28'h0000000, right_conv_enable,
				left_conv_enable, dsp_clk_en & any_path_on, cfg_ok};
		default: begin
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CMX_RESP_SLVERR;
		end
		endcase
	end else if (s_axi_rvalid && s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

// Microphone pin: two flops before use, then split by clock phase
always @(posedge aclk) begin
	if (!aresetn) begin
		pdm_meta_q <= 1'b0;
		pdm_sync_q <= 1'b0;
		pdm_phase_q <= 1'b0;
		pdm_left_q <= 1'b0;
		pdm_right_q <= 1'b0;
	end else begin
		pdm_meta_q <= pdm_microphone_data;
		pdm_sync_q <= pdm_meta_q;
		if (tick) begin
			pdm_phase_q <= ~pdm_phase_q;
			if (pdm_phase_q)
				pdm_left_q <= pdm_sync_q;
			else
				pdm_right_q <= pdm_sync_q;
		end
	end
end

// One-bit stream mapped to full-scale words; decimation is outside here
always @(posedge aclk) begin
	if (!aresetn) begin
		pdm_left_word_q <= {W{1'b0}};
		pdm_right_word_q <= {W{1'b0}};
	end else begin
		pdm_left_word_q <= pdm_left_q ? {1'b0, {(W-1){1'b1}}} :
			{1'b1, {(W-1){1'b0}}};
		pdm_right_word_q <= pdm_right_q ? {1'b0, {(W-1){1'b1}}} :
			{1'b1, {(W-1){1'b0}}};
	end
end

// Microphone takes the converter's place on the mixing input bus
assign left_src = power_q[`CMX_BIT_PDM_LEFT] ? pdm_left_word_q :
	left_conv_data;
assign right_src = power_q[`CMX_BIT_PDM_RIGHT] ? pdm_right_word_q :
	right_conv_data;

// Zero-order hold: a converter strobe without an interface-two strobe
// reuses the last pair, so the two rates may differ; no interpolation
always @(posedge aclk) begin
	if (!aresetn) begin
		if2_left_hold_q <= {W{1'b0}};
		if2_right_hold_q <= {W{1'b0}};
	end else if (iface_two_valid) begin
		if2_left_hold_q <= iface_two_left;
		if2_right_hold_q <= iface_two_right;
	end
end

assign if2_left_now = iface_two_valid ? iface_two_left :
	if2_left_hold_q;
assign if2_right_now = iface_two_valid ? iface_two_right :
	if2_right_hold_q;

cmx_mixer #(
	.W(W)
) u_mix_left (
	.a(left_src),
	.a_en(left_route_q[`CMX_BIT_CONV_ROUTE]),
	.b(if2_left_now),
	.b_en(left_route_q[`CMX_BIT_IF2_ROUTE]),
	.y(mix_left)
);

cmx_mixer #(
	.W(W)
) u_mix_right (
	.a(right_src),
	.a_en(right_route_q[`CMX_BIT_CONV_ROUTE]),
	.b(if2_right_now),
	.b_en(right_route_q[`CMX_BIT_IF2_ROUTE]),
	.y(mix_right)
);

// Enables, outputs and sidetone registered; converter enables shut when the DSP clock is off
always @(posedge aclk) begin
	if (!aresetn) begin
		left_conv_enable <= 1'b0;
		right_conv_enable <= 1'b0;
		clock_config_valid <= 1'b0;
		iface_one_left <= {W{1'b0}};
		iface_one_right <= {W{1'b0}};
		iface_one_valid <= 1'b0;
		sidetone_left <= {W{1'b0}};
		sidetone_right <= {W{1'b0}};
		sidetone_to_dac <= 1'b0;
		sidetone_to_iface_two <= 1'b0;
		sidetone_valid <= 1'b0;
	end else begin
		left_conv_enable <= power_q[`CMX_BIT_LEFT_CONV] & dsp_clk_en;
		right_conv_enable <= power_q[`CMX_BIT_RIGHT_CONV] &
			dsp_clk_en;
		clock_config_valid <= cfg_ok;
		// One stereo pair per interface, mixed on either sample strobe
		iface_one_valid <= conv_valid | iface_two_valid;
		if (conv_valid | iface_two_valid) begin
			iface_one_left <= mix_left;
			iface_one_right <= mix_right;
		end
		// Sidetone: converter if enabled, else microphone
		sidetone_valid <= conv_valid;
		sidetone_to_dac <= sidetone_q[`CMX_BIT_ST_TO_DAC];
		sidetone_to_iface_two <= sidetone_q[`CMX_BIT_ST_TO_IF2];
		if (conv_valid) begin
			sidetone_left <= power_q[`CMX_BIT_LEFT_CONV] ?
				left_conv_data : pdm_left_word_q;
			sidetone_right <= power_q[`CMX_BIT_RIGHT_CONV] ?
				right_conv_data : pdm_right_word_q;
		end
	end
end

endmodule // cmx_core

`default_nettype wire

// file: bench/cmx_core_assertions.sv
// Port checker for the converter clocking and output mixing core.
// Assumes one clock domain, aclk, with synchronous active-low aresetn.
`timescale 1ns/1ns
`default_nettype none
module cmx_core_chk (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Streams and clocking
	input wire logic conv_valid,
	input wire logic iface_two_valid,
	input wire logic iface_one_valid,
	input wire logic conv_clk_en,
	input wire logic clock_config_valid,
	input wire logic pdm_microphone_clk
);
	// Single domain, so clock and reset are stated once
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	mix_follow_a: assert property (
		(conv_valid || iface_two_valid) |=> iface_one_valid)
		else $error("mixed sample not issued");
	mix_quiet_a: assert property (
		!(conv_valid || iface_two_valid) |=> !iface_one_valid)
		else $error("mixed sample without input");
	clk_listed_a: assert property (
		conv_clk_en |-> clock_config_valid || $past(clock_config_valid))
		else $error("converter clock on unlisted setting");
	mic_clk_gate_a: assert property (
		$changed(pdm_microphone_clk) |-> conv_clk_en || $past(conv_clk_en))
		else $error("microphone clock moved without enable");
	wr_resp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rd_data_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rd_once_a: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read answered twice");
	wr_once_a: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write answered twice");
	rd_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
endmodule // cmx_core_chk

bind cmx_core cmx_core_chk u_chk (.aclk, .aresetn, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.conv_valid, .iface_two_valid, .iface_one_valid, .conv_clk_en,
	.clock_config_valid, .pdm_microphone_clk);
`default_nettype wire

// file: bench/cmx_src.sv
// Sample source standing in for the converters and interface two.
// Assumes the bench calls send() and aclk runs freely.
`timescale 1ns/1ns
`default_nettype none
module cmx_src #(
	parameter W = 24
) (
	// Clock
	input wire logic aclk,
	// Converter side
	output logic [W-1:0] left_conv_data,
	output logic [W-1:0] right_conv_data,
	output logic conv_valid,
	output logic pdm_microphone_data,
	// Interface two side
	output logic [W-1:0] iface_two_left,
	output logic [W-1:0] iface_two_right,
	output logic iface_two_valid
);
	// Idle values at time zero; no range control is ever switched on here
	initial begin
		{left_conv_data, right_conv_data} = '0;
		{iface_two_left, iface_two_right} = '0;
		{conv_valid, iface_two_valid, pdm_microphone_data} = '0;
	end

	// One stereo pair per interface on one strobe; gap models a slow source
	task automatic send(input [W-1:0] l, r, a, b, input int gap);
		repeat (gap) @(posedge aclk);
		@(posedge aclk);
		{left_conv_data, right_conv_data} <= {l, r};
		{iface_two_left, iface_two_right} <= {a, b};
		{conv_valid, iface_two_valid} <= 2'b11;
		pdm_microphone_data <= ~pdm_microphone_data;
		@(posedge aclk);
		{conv_valid, iface_two_valid} <= 2'b00;
		// Stale data inverted so a late capture cannot match
		{left_conv_data, right_conv_data} <= ~{l, r};
		{iface_two_left, iface_two_right} <= ~{a, b};
	endtask

	// Converter strobe alone, as when the two interface rates differ
	task automatic send_conv(input [W-1:0] l, r);
		@(posedge aclk);
		{left_conv_data, right_conv_data} <= {l, r};
		conv_valid <= 1'b1;
		@(posedge aclk);
		conv_valid <= 1'b0;
		{left_conv_data, right_conv_data} <= ~{l, r};
	endtask
endmodule // cmx_src
`default_nettype wire

// file: bench/cmx_core_tb.sv
// Self-checking bench for the converter clocking and mixing core.
// Assumes cmx_defs.vh on the include path and the checker bound in.
`timescale 1ns/1ns
`default_nettype none
`include "cmx_defs.vh"
`define CHK(g, e) begin \
	checked++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("mismatch t=%0t got %h exp %h", $time, (g), (e)); \
	end \
end
module cmx_core_tb;
	logic aclk = 0;
	logic aresetn = 0;
	logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'h3;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, conv_valid, iface_two_valid, pdm_microphone_data;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [23:0] left_conv_data, right_conv_data;
	logic [23:0] iface_two_left, iface_two_right, iface_one_left;
	logic [23:0] iface_one_right, sidetone_left, sidetone_right;
	logic left_conv_enable, right_conv_enable, conv_clk_en;
	logic pdm_microphone_clk, clock_config_valid, iface_one_valid;
	logic sidetone_to_dac, sidetone_to_iface_two, sidetone_valid;
	int n_fail = 0;
	int checked = 0;
	// Clocking, if1 rate, if2 rate, expected listed flag
	logic [15:0] ctab [8][4] = '{
		'{16'h0003, 16'h0082, 16'h0083, 16'h1}, '{16'h0003, 16'h0083,
		16'h0082, 16'h0}, '{16'h000B, 16'h0083, 16'h0082, 16'h1},
		'{16'h000B, 16'h0082, 16'h0083, 16'h0}, '{16'h0003, 16'h0002,
		16'h0083, 16'h0}, '{16'h0002, 16'h0002, 16'h0083, 16'h1},
		'{16'h0002, 16'h0080, 16'h0083, 16'h0}, '{16'h0003, 16'h0004,
		16'h0083, 16'h1}};

	// 100 MHz clock
	always #5 aclk = ~aclk;

	cmx_src u_src (.aclk, .left_conv_data, .right_conv_data, .conv_valid,
		.pdm_microphone_data, .iface_two_left, .iface_two_right,
		.iface_two_valid);

	cmx_core #(.W(24), .DIV_W(8)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.left_conv_data, .right_conv_data, .conv_valid,
		.pdm_microphone_data, .iface_two_left, .iface_two_right,
		.iface_two_valid, .left_conv_enable, .right_conv_enable,
		.conv_clk_en, .pdm_microphone_clk, .clock_config_valid,
		.iface_one_left, .iface_one_right, .iface_one_valid,
		.sidetone_left, .sidetone_right, .sidetone_to_dac,
		.sidetone_to_iface_two, .sidetone_valid);

	// Ready is sampled at the falling edge, acted on at the rising edge
	task automatic wr(input [11:0] idx, input [15:0] v);
		int n;
		logic ta, tw, tb;
		logic [1:0] br;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {16'h0000, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			{tb, br} = {s_axi_bvalid, s_axi_bresp};
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			n++;
		end while (!tb && n < 50);
		s_axi_bready <= 1'b0;
		`CHK(tb, 1'b1)
		`CHK(br, `CMX_RESP_OKAY)
	endtask

	task automatic rd(input [11:0] idx, output [31:0] d, output [1:0] r);
		int n;
		logic ta, tr;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			{tr, d, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			n++;
		end while (!tr && n < 50);
		s_axi_rready <= 1'b0;
		`CHK(tr, 1'b1)
	endtask

	task automatic chkreg(input [11:0] idx, input [15:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(idx, d, r);
		`CHK(d, {16'h0000, e})
		`CHK(r, `CMX_RESP_OKAY)
	endtask

	task automatic mix(input [23:0] l, r, a, b, el, er, input int g);
		int n;
		u_src.send(l, r, a, b, g);
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!iface_one_valid && n < 6);
		`CHK(iface_one_left, el)
		`CHK(iface_one_right, er)
		`CHK(iface_one_valid, 1'b1)
		`CHK(sidetone_valid, 1'b1)
		`CHK(sidetone_left, l)
		`CHK(sidetone_right, r)
	endtask

	task automatic pulse(output logic seen);
		seen = 0;
		repeat (600) begin
			@(negedge aclk);
			seen |= conv_clk_en;
		end
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		chkreg(`CMX_IDX_POWER, 16'h0000);
		chkreg(`CMX_IDX_CLOCKING, 16'h0001);
		chkreg(`CMX_IDX_LEFT_ROUTE, 16'h0000);
		chkreg(`CMX_IDX_RIGHT_ROUTE, 16'h0000);
		rd(12'h005, d, r);
		`CHK(r, `CMX_RESP_SLVERR)
		`CHK(d, 32'h0000_0000)
	endtask

	task automatic t_enable();
		wr(`CMX_IDX_IF1_RATE, 16'h0082);
		wr(`CMX_IDX_CLOCKING, 16'h0003);
		wr(`CMX_IDX_POWER, 16'h0001);
		repeat (2) @(negedge aclk);
		`CHK(right_conv_enable, 1'b1)
		`CHK(left_conv_enable, 1'b0)
		wr(`CMX_IDX_POWER, 16'h0003);
		repeat (2) @(negedge aclk);
		`CHK(left_conv_enable, 1'b1)
	endtask

	task automatic t_mix();
		wr(`CMX_IDX_SIDETONE, 16'h0001);
		wr(`CMX_IDX_LEFT_ROUTE, 16'h0003);
		wr(`CMX_IDX_RIGHT_ROUTE, 16'h0003);
		chkreg(`CMX_IDX_LEFT_ROUTE, 16'h0003);
		mix(24'h100000, 24'h10, 24'h123, 24'h20, 24'h100123, 24'h30, 0);
		`CHK({sidetone_to_iface_two, sidetone_to_dac}, 2'b01)
		mix(24'h700000, 24'h900000, 24'h200000, 24'h900000, 24'h7FFFFF,
			24'h800000, 3);
		wr(`CMX_IDX_LEFT_ROUTE, 16'h0002);
		wr(`CMX_IDX_RIGHT_ROUTE, 16'h0001);
		mix(24'h111111, 24'h222222, 24'h333333, 24'h044444, 24'h111111,
			24'h044444, 0);
		wr(`CMX_IDX_LEFT_ROUTE, 16'h0001);
		wr(`CMX_IDX_RIGHT_ROUTE, 16'h0002);
		mix(24'h111111, 24'h222222, 24'h333333, 24'h044444, 24'h333333,
			24'h222222, 1);
		wr(`CMX_IDX_LEFT_ROUTE, 16'h0000);
		wr(`CMX_IDX_RIGHT_ROUTE, 16'h0000);
		mix(24'h111111, 24'h222222, 24'h333333, 24'h044444, 24'h0, 24'h0,
			0);
		wr(`CMX_IDX_LEFT_ROUTE, 16'h0003);
		wr(`CMX_IDX_RIGHT_ROUTE, 16'h0003);
		mix(24'h000100, 24'h000200, 24'h000010, 24'h000020, 24'h000110,
			24'h000220, 0);
		// Interface-two data has gone stale; the held pair must be used
		u_src.send_conv(24'h001000, 24'h002000);
		@(negedge aclk);
		`CHK(iface_one_left, 24'h001010)
		`CHK(iface_one_right, 24'h002020)
		// Microphone left takes the converter's mixer input, not sidetone
		wr(`CMX_IDX_POWER, 16'h000B);
		wr(`CMX_IDX_LEFT_ROUTE, 16'h0002);
		u_src.send(24'h111111, 24'h222222, 24'h0, 24'h0, 0);
		@(negedge aclk);
		`CHK(iface_one_left[22:0] == {23{~iface_one_left[23]}}, 1'b1)
		`CHK(sidetone_left, 24'h111111)
	endtask

	task automatic t_clock();
		logic seen;
		for (int i = 0; i < 8; i++) begin
			wr(`CMX_IDX_IF1_RATE, ctab[i][1]);
			wr(`CMX_IDX_IF2_RATE, ctab[i][2]);
			wr(`CMX_IDX_CLOCKING, ctab[i][0]);
			pulse(seen);
			`CHK(clock_config_valid, ctab[i][3][0])
			`CHK(seen, ctab[i][3][0])
		end
		wr(`CMX_IDX_CLOCKING, 16'h0001);
		pulse(seen);
		`CHK(seen, 1'b0)
		`CHK(right_conv_enable, 1'b0)
	endtask

	task automatic summarize();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence: reset held for three cycles
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_enable();
		t_mix();
		t_clock();
		summarize();
	end

	// Watchdog well past the expected run of some 5600 cycles
	initial begin
		#500000;
		n_fail++;
		summarize();
	end
endmodule // cmx_core_tb
`default_nettype wire
